/* File: src/sleep_pkg.sv */
package sleep_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int PRIO_W  = 8;
  localparam int BUS_IFS = 2;
  localparam int OUTST_W = 4;
  localparam int LIMIT_W = 16;
  localparam int WAKES_W = 16;
  localparam int CTRL_W  = 4;
  localparam int STAT_W  = 4;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] LIMIT_OFS  = 8'h08;
  localparam logic [ADDR_W-1:0] WAKES_OFS  = 8'h0c;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int CTRL_PEND_BIT  = 0;
  localparam int CTRL_EVSLP_BIT = 1;
  localparam int CTRL_IRSLP_BIT = 2;
  localparam int CTRL_DEEP_BIT  = 3;
  localparam int STAT_SLEEP_BIT = 0;
  localparam int STAT_IRQW_BIT  = 1;
  localparam int STAT_IDLE_BIT  = 2;
  localparam int STAT_PDN_BIT   = 3;

  localparam logic [CTRL_W-1:0]  CTRL_RST  = 4'h6;
  localparam logic [LIMIT_W-1:0] LIMIT_RST = 16'h0000;
  localparam logic               LATCH_RST = 1'b0;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    ST_RUN      = 2'b00,
    ST_WAIT_EVT = 2'b01,
    ST_WAIT_IRQ = 2'b10
  } sleep_state_e;

  typedef logic [PRIO_W-1:0] prio_t;
  typedef logic [OUTST_W-1:0] outst_t;

  // lower number means more urgent
  function automatic logic prio_above(input prio_t a, input prio_t b);
    return a < b;
  endfunction

  // outstanding-transfer count update, saturating at both ends
  function automatic outst_t outst_next(input outst_t c, input logic inc, input logic dec);
    outst_t r;
    r = c;
    if (inc && !dec && c != {OUTST_W{1'b1}}) begin
      r = c + outst_t'(1);
    end else if (dec && !inc && c != '0) begin
      r = c - outst_t'(1);
    end
    return r;
  endfunction

endpackage

/* File: src/sleep_wake_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sleep_wake_if;
  import sleep_pkg::*;
  logic  irq_valid;
  prio_t irq_prio;
  logic  active_valid;
  prio_t active_prio;
  logic  priority_mask_bit;
  logic  fault_mask_bit;
  prio_t base_priority_threshold;
  logic  irq_wake;
  logic  prio_wake;

  modport eval (
    input  irq_valid, irq_prio, active_valid, active_prio,
    input  priority_mask_bit, fault_mask_bit, base_priority_threshold,
    output irq_wake, prio_wake
  );
  modport ctrl (
    output irq_valid, irq_prio, active_valid, active_prio,
    output priority_mask_bit, fault_mask_bit, base_priority_threshold,
    input  irq_wake, prio_wake
  );
endinterface
`default_nettype wire

/* File: src/wake_prio_eval.sv */
`timescale 1ns/1ps
`default_nettype none
module wake_prio_eval (
  sleep_wake_if.eval wk
);
  import sleep_pkg::*;

  // ************************************************************
  // priority comparison
  // ************************************************************
  logic beats_active;
  logic beats_base;
  logic unmasked;

  // must outrank every active exception and a non-zero threshold
  assign beats_active = !wk.active_valid || prio_above(wk.irq_prio, wk.active_prio);
  assign beats_base   = (wk.base_priority_threshold == '0) ||
                        prio_above(wk.irq_prio, wk.base_priority_threshold);
  // fault mask lifts execution priority above any interrupt
  assign unmasked     = wk.irq_valid && !wk.fault_mask_bit && beats_active && beats_base;

  // priority mask does not stop the interrupt-wait exit
  assign wk.irq_wake  = unmasked;
  // event-wait wake needs a real pre-emption, so mask applies
  assign wk.prio_wake = unmasked && !wk.priority_mask_bit;
endmodule
`default_nettype wire

/* File: src/wait_event_sleep_control.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// - one event latch, reset value not relied on
// - wake events and exception return set latch
// - only event-wait instruction clears latch
// - latch has no software read or write
// - send-event sets every processor's latch
// - latch set: clear it, complete at once
// - latch clear: may sleep until wake
// - wake completes event-wait; early exit allowed
// - early wake events stay captured in latch
// - resume policy fixed: latch not cleared
// - interrupt-wait may sleep until wake
// - interrupt wake: pre-empting exception or debug
// - mask set: outrank active and threshold
// - wake completes interrupt-wait; early exit allowed
// - interrupt wake seen only after issue
// - sleeping halts execution and bus traffic
// - report bus idle to power controller
// - send-on-pend: new pending sets latch
module wait_event_sleep_control (
  input  wire  logic                          clk,
  input  wire  logic                          rstn,
  // register port
  input  wire  logic [sleep_pkg::ADDR_W-1:0]  addr,
  input  wire  logic [sleep_pkg::DATA_W-1:0]  wdata,
  input  wire  logic                          wr_en,
  input  wire  logic                          rd_en,
  output logic       [sleep_pkg::DATA_W-1:0]  rdata,
  // instruction side
  input  wire  logic                          wait_for_event_instr,
  input  wire  logic                          wait_for_interrupt_instr,
  input  wire  logic                          send_event_instr,
  input  wire  logic                          exc_return,
  output logic                                instr_done,
  output logic                                sleeping,
  // other processors
  input  wire  logic                          event_in,
  output logic                                event_out,
  // exception context
  input  wire  logic                          pend_new,
  input  wire  logic                          irq_valid,
  input  wire  sleep_pkg::prio_t              irq_prio,
  input  wire  logic                          active_valid,
  input  wire  sleep_pkg::prio_t              active_prio,
  input  wire  logic                          priority_mask_bit,
  input  wire  logic                          fault_mask_bit,
  input  wire  sleep_pkg::prio_t              base_priority_threshold,
  input  wire  logic                          debug_event,
  input  wire  logic                          debug_enable,
  // bus interfaces and power controller
  input  wire  logic [sleep_pkg::BUS_IFS-1:0] bus_start,
  input  wire  logic [sleep_pkg::BUS_IFS-1:0] bus_end,
  output logic                                bus_idle,
  output logic                                power_down_req,
  output logic                                deep_sleep
);
  import sleep_pkg::*;

  // ************************************************************
  // declarations
  // ************************************************************
  sleep_state_e            state_r;
  sleep_state_e            state_nxt;
  logic                    event_r;
  logic [CTRL_W-1:0]       ctrl_r;
  logic [LIMIT_W-1:0]      limit_r;
  logic [LIMIT_W-1:0]      sleep_cnt_r;
  logic [WAKES_W-1:0]      wakes_r;
  outst_t                  outst_r [BUS_IFS];
  outst_t                  outst_nxt [BUS_IFS];
  logic                    idle_nxt;
  logic                    done_r;
  logic                    done_nxt;
  logic                    sleeping_r;
  logic                    event_out_r;
  logic                    bus_idle_r;
  logic                    pdn_r;
  logic                    deep_r;
  logic [DATA_W-1:0]       rdata_r;
  logic                    dbg_wake;
  logic                    evt_wake;
  logic                    event_set;
  logic                    event_clear;
  logic                    take_evt;
  logic                    take_irq;
  logic                    timeout;
  logic                    leaving;

  sleep_wake_if wk ();

  // ************************************************************
  // priority evaluation
  // ************************************************************
  // context goes to the evaluator through the interface
  assign wk.irq_valid               = irq_valid;
  assign wk.irq_prio                = irq_prio;
  assign wk.active_valid            = active_valid;
  assign wk.active_prio             = active_prio;
  assign wk.priority_mask_bit       = priority_mask_bit;
  assign wk.fault_mask_bit          = fault_mask_bit;
  assign wk.base_priority_threshold = base_priority_threshold;

  wake_prio_eval u_prio (
    .wk (wk.eval)
  );

  // ************************************************************
  // wake sources
  // ************************************************************
  // debug entry wakes both kinds of wait
  assign dbg_wake = debug_event && debug_enable;

  // anything that counts as an event-wait wake-up
  assign evt_wake = event_in
                  || send_event_instr
                  || (pend_new && ctrl_r[CTRL_PEND_BIT])
                  || wk.prio_wake
                  || dbg_wake;

  // exception return sets the latch but does not end a sleep
  assign event_set = evt_wake || exc_return;

  // ************************************************************
  // instruction acceptance
  // ************************************************************
  // instructions only arrive while running; interrupt-wait wins a tie
  assign take_irq = (state_r == ST_RUN) && wait_for_interrupt_instr;
  assign take_evt = (state_r == ST_RUN) && wait_for_event_instr && !wait_for_interrupt_instr;

  // consuming a recorded event is the only way the latch drops
  assign event_clear = take_evt && event_r;

  // optional early exit, zero limit disables it
  assign timeout = (limit_r != '0) && (sleep_cnt_r >= limit_r - LIMIT_W'(1));

  // ************************************************************
  // event latch
  // ************************************************************
  // a set arriving with the clear survives, so no event is lost;
  // the reset value is a constant but callers must not rely on it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      event_r <= LATCH_RST;
    end else begin
      event_r <= event_set || (event_r && !event_clear);
    end
  end

  // ************************************************************
  // sleep sequencer
  // ************************************************************
  // next state and completion pulse
  always_comb begin
    state_nxt = state_r;
    done_nxt  = 1'b0;
    case (state_r)
      ST_RUN: begin
        if (take_irq) begin
          if (ctrl_r[CTRL_IRSLP_BIT]) begin
            state_nxt = ST_WAIT_IRQ;
          end else begin
            done_nxt = 1'b1;
          end
        end else if (take_evt) begin
          if (event_r || !ctrl_r[CTRL_EVSLP_BIT]) begin
            done_nxt = 1'b1;
          end else begin
            state_nxt = ST_WAIT_EVT;
          end
        end
      end
      ST_WAIT_EVT: begin
        // latch is left set after the wake-up
        if (evt_wake || timeout) begin
          state_nxt = ST_RUN;
          done_nxt  = 1'b1;
        end
      end
      ST_WAIT_IRQ: begin
        // wake looked at only from inside the wait
        if (wk.irq_wake || dbg_wake || timeout) begin
          state_nxt = ST_RUN;
          done_nxt  = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  assign leaving = (state_r != ST_RUN) && (state_nxt == ST_RUN);

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // completion pulse and sleeping flag change on the same edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      done_r     <= 1'b0;
      sleeping_r <= 1'b0;
    end else begin
      done_r     <= done_nxt;
      sleeping_r <= (state_nxt != ST_RUN);
    end
  end

  // ************************************************************
  // early-exit timer and wake count
  // ************************************************************
  // counts cycles spent asleep; restarts on every entry
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sleep_cnt_r <= '0;
    end else if (state_r == ST_RUN) begin
      sleep_cnt_r <= '0;
    end else if (sleep_cnt_r != {LIMIT_W{1'b1}}) begin
      sleep_cnt_r <= sleep_cnt_r + LIMIT_W'(1);
    end
  end

  // saturating count of resumptions, handy for idle statistics
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wakes_r <= '0;
    end else if (leaving && wakes_r != {WAKES_W{1'b1}}) begin
      wakes_r <= wakes_r + WAKES_W'(1);
    end
  end

  // ************************************************************
  // send-event broadcast
  // ************************************************************
  // one-cycle pulse to every other processor; the local latch is
  // set directly, so the own pulse is not looped back
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      event_out_r <= 1'b0;
    end else begin
      event_out_r <= send_event_instr;
    end
  end

  // ************************************************************
  // bus activity tracking
  // ************************************************************
  // per-interface outstanding transfer count
  always_comb begin
    idle_nxt = 1'b1;
    for (int i = 0; i < BUS_IFS; i++) begin
      outst_nxt[i] = outst_next(outst_r[i], bus_start[i], bus_end[i]);
      if (outst_nxt[i] != '0) begin
        idle_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < BUS_IFS; i++) begin
        outst_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < BUS_IFS; i++) begin
        outst_r[i] <= outst_nxt[i];
      end
    end
  end

  // power-down only offered from the interrupt wait, and only once
  // the last transfer has drained, so no response is dropped
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_idle_r <= 1'b1;
      pdn_r      <= 1'b0;
      deep_r     <= 1'b0;
    end else begin
      bus_idle_r <= idle_nxt;
      pdn_r      <= (state_nxt == ST_WAIT_IRQ) && idle_nxt;
      deep_r     <= (state_nxt == ST_WAIT_IRQ) && idle_nxt && ctrl_r[CTRL_DEEP_BIT];
    end
  end

  // ************************************************************
  // register port
  // ************************************************************
  // writable settings
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r  <= CTRL_RST;
      limit_r <= LIMIT_RST;
    end else if (wr_en) begin
      case (addr)
        CTRL_OFS:  ctrl_r  <= wdata[CTRL_W-1:0];
        LIMIT_OFS: limit_r <= wdata[LIMIT_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // read data valid in the cycle after the strobe only;
  // the event latch is deliberately absent from every word
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= '0;
      if (rd_en) begin
        case (addr)
          CTRL_OFS: begin
            rdata_r <= DATA_W'(ctrl_r);
          end
          STATUS_OFS: begin
            rdata_r[STAT_SLEEP_BIT] <= sleeping_r;
            rdata_r[STAT_IRQW_BIT]  <= (state_r == ST_WAIT_IRQ);
            rdata_r[STAT_IDLE_BIT]  <= bus_idle_r;
            rdata_r[STAT_PDN_BIT]   <= pdn_r;
          end
          LIMIT_OFS: begin
            rdata_r <= DATA_W'(limit_r);
          end
          WAKES_OFS: begin
            rdata_r <= DATA_W'(wakes_r);
          end
          default: begin
            rdata_r <= '0;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign rdata          = rdata_r;
  assign instr_done     = done_r;
  assign sleeping       = sleeping_r;
  assign event_out      = event_out_r;
  assign bus_idle       = bus_idle_r;
  assign power_down_req = pdn_r;
  assign deep_sleep     = deep_r;

endmodule
`default_nettype wire

/* File: verification/sleep_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// sleep control port checks
// ************************************************************
module sleep_props (
  input wire logic                          clk,
  input wire logic                          rstn,
  input wire logic                          wait_for_event_instr,
  input wire logic                          wait_for_interrupt_instr,
  input wire logic                          send_event_instr,
  input wire logic                          instr_done,
  input wire logic                          sleeping,
  input wire logic                          event_in,
  input wire logic                          event_out,
  input wire logic                          irq_valid,
  input wire sleep_pkg::prio_t              irq_prio,
  input wire logic                          active_valid,
  input wire sleep_pkg::prio_t              active_prio,
  input wire logic                          priority_mask_bit,
  input wire logic                          fault_mask_bit,
  input wire sleep_pkg::prio_t              base_priority_threshold,
  input wire logic                          debug_event,
  input wire logic                          debug_enable,
  input wire logic [sleep_pkg::BUS_IFS-1:0] bus_start,
  input wire logic [sleep_pkg::BUS_IFS-1:0] bus_end,
  input wire logic                          bus_idle,
  input wire logic                          power_down_req
);
  import sleep_pkg::*;
  logic in_irq_r;
  logic irq_ok;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // remembers which wait put the core to sleep
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_irq_r <= 1'b0;
    end else if (!sleeping) begin
      in_irq_r <= wait_for_interrupt_instr;
    end
  end
  // exception outranks active set and threshold
  assign irq_ok = irq_valid && !fault_mask_bit && (!active_valid || irq_prio < active_prio)
    && (base_priority_threshold == '0 || irq_prio < base_priority_threshold);
  sev_out_a: assert property (send_event_instr |=> event_out)
    else $error("no broadcast after send");
  sleep_cause_a: assert property ($rose(sleeping) |-> $past(wait_for_event_instr) || $past(wait_for_interrupt_instr))
    else $error("sleep without wait");
  resume_done_a: assert property ($fell(sleeping) |-> instr_done)
    else $error("resume without completion");
  wfi_take_a: assert property (wait_for_interrupt_instr && !sleeping |=> sleeping || instr_done)
    else $error("interrupt wait not taken");
  irq_wake_a: assert property (sleeping && irq_ok && (in_irq_r || !priority_mask_bit) |=> !sleeping && instr_done)
    else $error("exception did not wake");
  dbg_wake_a: assert property (sleeping && debug_event && debug_enable |=> !sleeping ##0 instr_done)
    else $error("debug did not wake");
  evt_wake_a: assert property (sleeping && !in_irq_r && event_in |=> !sleeping && instr_done)
    else $error("event did not wake");
  bus_busy_a: assert property ((bus_start & ~bus_end) != '0 |=> !bus_idle)
    else $error("idle with transfer out");
  pdn_sleep_a: assert property (power_down_req |-> sleeping)
    else $error("power down while running");
endmodule
bind wait_event_sleep_control sleep_props chk (.clk, .rstn, .wait_for_event_instr, .wait_for_interrupt_instr,
  .send_event_instr, .instr_done, .sleeping, .event_in, .event_out, .irq_valid, .irq_prio, .active_valid,
  .active_prio, .priority_mask_bit, .fault_mask_bit, .base_priority_threshold, .debug_event, .debug_enable,
  .bus_start, .bus_end, .bus_idle, .power_down_req);
`default_nettype wire

/* File: verification/peer_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// other cores and power controller
// ************************************************************
module peer_model (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic event_out,
  input  wire logic power_down_req,
  output logic      event_in
);
  int rx_count;
  int pd_cycles;
  initial event_in = 1'b0;
  // peers latch each broadcast; controller counts idle time
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_count <= 0;
      pd_cycles <= 0;
    end else begin
      if (event_out) rx_count <= rx_count + 1;
      if (power_down_req) pd_cycles <= pd_cycles + 1;
    end
  end
  // a send-event from another core, one cycle wide
  task automatic broadcast();
    @(posedge clk);
    event_in <= 1'b1;
    @(posedge clk);
    event_in <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verification/wait_event_sleep_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// sleep control bench
// ************************************************************
module wait_event_sleep_control_test;
  import sleep_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic wait_for_event_instr = 1'b0, wait_for_interrupt_instr = 1'b0, send_event_instr = 1'b0;
  logic exc_return = 1'b0, pend_new = 1'b0, irq_valid = 1'b0, active_valid = 1'b0;
  logic priority_mask_bit = 1'b0, fault_mask_bit = 1'b0, debug_event = 1'b0, debug_enable = 1'b0;
  prio_t irq_prio = 8'h00, active_prio = 8'h00, base_priority_threshold = 8'h00;
  logic [BUS_IFS-1:0] bus_start = '0, bus_end = '0;
  logic instr_done, sleeping, event_in, event_out, bus_idle, power_down_req, deep_sleep;
  int fail_count = 0, checked = 0, cycles = 0, ev = 0;
  wait_event_sleep_control dut (.clk, .rstn, .addr, .wdata, .wr_en, .rd_en, .rdata, .wait_for_event_instr,
    .wait_for_interrupt_instr, .send_event_instr, .exc_return, .instr_done, .sleeping, .event_in, .event_out,
    .pend_new, .irq_valid, .irq_prio, .active_valid, .active_prio, .priority_mask_bit, .fault_mask_bit,
    .base_priority_threshold, .debug_event, .debug_enable, .bus_start, .bus_end, .bus_idle,
    .power_down_req, .deep_sleep);
  peer_model peer (.clk, .rstn, .event_out, .power_down_req, .event_in);
  always #2.5 clk = ~clk;
  // hang guard, far above the planned run
  always @(posedge clk) begin
    cycles++;
    if (cycles > 4000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // read data is looked at only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 check(nm, rdata, exp);
  endtask
  task automatic expect_st(input logic s, input logic d);
    check("sleeping", 32'(sleeping), 32'(s));
    check("instr_done", 32'(instr_done), 32'(d));
  endtask
  // one-cycle instruction pulse, then look just after the edge that takes it
  task automatic pulse(input int k);
    @(posedge clk);
    case (k)
      0: wait_for_event_instr <= 1'b1;
      1: wait_for_interrupt_instr <= 1'b1;
      2: send_event_instr <= 1'b1;
      3: exc_return <= 1'b1;
      default: pend_new <= 1'b1;
    endcase
    @(posedge clk);
    {wait_for_event_instr, wait_for_interrupt_instr, send_event_instr, exc_return, pend_new} <= '0;
    #1;
  endtask
  // latch model decides between quick return and sleep
  task automatic wait_ev();
    pulse(0);
    if (ev != 0) begin
      expect_st(1'b0, 1'b1);
      ev = 0;
    end else begin
      expect_st(1'b1, 1'b0);
    end
  endtask
  initial begin
    void'($urandom(19));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    reg_rd(CTRL_OFS, 32'(CTRL_RST), "ctrl");
    reg_rd(LIMIT_OFS, 32'h0, "limit");
    reg_wr(STATUS_OFS, 32'hf);
    reg_rd(STATUS_OFS, 32'h4, "status");
    reg_rd(8'h10, 32'h0, "unmapped");
    reg_wr(CTRL_OFS, 32'h7);
    reg_rd(CTRL_OFS, 32'h7, "ctrl");
    pulse(2);
    ev = 1;
    check("event_out", 32'(event_out), 32'h1);
    tick(1);
    check("peer_rx", peer.rx_count, 32'h1);
    wait_ev();
    wait_ev();
    pulse(3);
    ev = 1;
    expect_st(1'b1, 1'b0);
    peer.broadcast();
    #1;
    expect_st(1'b0, 1'b1);
    wait_ev();
    pulse(4);
    ev = 1;
    wait_ev();
    reg_wr(CTRL_OFS, 32'h6);
    pulse(4);
    wait_ev();
    @(posedge clk);
    debug_enable <= 1'b1;
    debug_event <= 1'b1;
    tick(1);
    expect_st(1'b0, 1'b1);
    debug_event <= 1'b0;
    ev = 1;
    wait_ev();
    @(posedge clk);
    active_valid <= 1'b1;
    active_prio <= 8'h40;
    base_priority_threshold <= 8'h20;
    priority_mask_bit <= 1'b1;
    bus_start <= 2'b01;
    @(posedge clk);
    bus_start <= '0;
    tick(1);
    check("bus_idle", 32'(bus_idle), 32'h0);
    pulse(1);
    expect_st(1'b1, 1'b0);
    reg_rd(STATUS_OFS, 32'h3, "status");
    check("power_down_req", 32'(power_down_req), 32'h0);
    @(posedge clk);
    bus_end <= 2'b01;
    @(posedge clk);
    bus_end <= '0;
    tick(2);
    check("power_down_req", 32'(power_down_req), 32'h1);
    peer.broadcast();
    tick(1);
    ev = 1;
    expect_st(1'b1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      irq_valid <= 1'b1;
      irq_prio <= 8'h40 + 8'($urandom_range(191));
      tick(2);
      expect_st(1'b1, 1'b0);
    end
    irq_prio <= 8'h30;
    tick(2);
    expect_st(1'b1, 1'b0);
    irq_prio <= 8'h10 + 8'($urandom_range(15));
    tick(1);
    expect_st(1'b0, 1'b1);
    irq_valid <= 1'b0;
    check("pd_seen", 32'(peer.pd_cycles != 0), 32'h1);
    reg_wr(CTRL_OFS, 32'he);
    debug_event <= 1'b1;
    @(posedge clk);
    debug_event <= 1'b0;
    pulse(1);
    expect_st(1'b1, 1'b0);
    tick(1);
    check("deep_sleep", 32'(deep_sleep), 32'h1);
    debug_event <= 1'b1;
    tick(1);
    expect_st(1'b0, 1'b1);
    debug_event <= 1'b0;
    priority_mask_bit <= 1'b0;
    wait_ev();
    wait_ev();
    irq_valid <= 1'b1;
    irq_prio <= 8'h10;
    tick(1);
    expect_st(1'b0, 1'b1);
    irq_valid <= 1'b0;
    ev = 1;
    wait_ev();
    // early exit after four cycles asleep
    reg_wr(LIMIT_OFS, 32'h4);
    wait_ev();
    tick(3);
    expect_st(1'b1, 1'b0);
    tick(1);
    expect_st(1'b0, 1'b1);
    reg_rd(WAKES_OFS, 32'h6, "wakes");
    wrap_up();
  end
endmodule
`default_nettype wire
